// File: include/ccr_defs.svh
// Purpose : constants for the charger configuration and charge-current register bank
// Assumes : two-wire serial slave port, 125 MHz core clock
// Notes   : offsets are register addresses as seen on the serial bus
//
// Overview of operation
// R01 - writing one to register-reset restores all host registers; device mode unchanged
// R02 - writing one to watchdog-restart restarts the serial-port watchdog; zero does nothing
// R03 - host leaves at least 20 us between two watchdog-restart writes
// R04 - boost-output enable turns the OTG boost output on; reset value zero
// R05 - boost-output enable overrides charge-enable and keeps charging off
// R06 - charge-enable allows charging when one; reset value one
// R07 - minimum system voltage is 3.0 V plus 0.4/0.2/0.1 V weights; default 101
// R08 - fast-charge current is 512 mA plus 64 mA steps; default 011000
// R09 - host never programs a fast-charge code above 100111 (3008 mA)
// R10 - cold-threshold select chooses 76 or 79 percent of regulator rail; default zero
// R11 - forced-reduced-current scales fast charge to 20 and pre-charge to 50 percent
// R12 - charge-current control register reads 01100000 after reset
// R13 - both registers are read and written through the serial port at address 6BH
// R14 - register-reset and watchdog-restart act once and read back as zero
`ifndef CCR_DEFS_SVH
`define CCR_DEFS_SVH

// ****************************************************************
// bus addressing
// ****************************************************************
`define CCR_DEV_ADDR       7'h6B
`define CCR_OFS_CFG        8'h01
`define CCR_OFS_CHG        8'h02

// ****************************************************************
// field positions and reset values
// ****************************************************************
`define CCR_BIT_REG_RST    7
`define CCR_BIT_WDT_RST    6
`define CCR_CFG_RST        8'h1B
`define CCR_CHG_RST        8'h60
// decoded reset levels: 3500 mV and 2048 mA, kept literal for the async branch
`define CCR_SYS_RST_MV     13'h0DAC
`define CCR_FCHG_RST_MA    13'h0800

// ****************************************************************
// decode weights, millivolt and milliamp units
// ****************************************************************
`define CCR_SYS_BASE_MV    13'h0BB8
`define CCR_SYS_STEP_MV    13'h0064
`define CCR_FCHG_BASE_MA   13'h0200
`define CCR_FCHG_STEP_MA   13'h0040
`define CCR_FCHG_DIV       13'h0005

// ****************************************************************
// timing
// ****************************************************************
`define CCR_CLK_PERIOD_NS  8
`define CCR_WDT_GAP_NS     20000
`define CCR_WDT_GAP_CYC    ((`CCR_WDT_GAP_NS + `CCR_CLK_PERIOD_NS - 1) / `CCR_CLK_PERIOD_NS)

`endif

// File: include/ccr_pkg.sv
// Purpose : types shared by the register bank files
// Assumes : nothing beyond the constants header
// Notes   : struct layouts follow the register bit order, msb first
`default_nettype none

package ccr_pkg;

	// serial transaction states, one-hot
	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_ADDR    = 9'h002,
		ST_ADDR_AK = 9'h004,
		ST_REG     = 9'h008,
		ST_REG_AK  = 9'h010,
		ST_WR      = 9'h020,
		ST_WR_AK   = 9'h040,
		ST_RD      = 9'h080,
		ST_RD_AK   = 9'h100
	} ccr_state_e;

	// power-on configuration register
	typedef struct packed {
		logic       reg_reset;
		logic       wdt_restart;
		logic       boost_output_enable;
		logic       charge_enable_bit;
		logic [2:0] min_system_voltage;
		logic       boost_ilim_hi;
	} ccr_cfg_s;

	// charge-current control register
	typedef struct packed {
		logic [5:0] fast_charge_current;
		logic       bcold_sel;
		logic       forced_reduced_current;
	} ccr_chg_s;

	// bus line events
	typedef struct packed {
		logic scl_rise;
		logic scl_fall;
		logic start;
		logic stop;
		logic sda;
	} ccr_line_s;

endpackage : ccr_pkg

`default_nettype wire

// File: src/ccr_line_mon.sv
// Purpose : edge, start and stop detection on the serial clock and data lines
// Assumes : lines already synchronous to the core clock
// Notes   : events are one-cycle pulses, one cycle after the line change
`timescale 1ns/1ps
`default_nettype none

module ccr_line_mon
	import ccr_pkg::*;
(
	input  wire logic  i_clk,
	input  wire logic  i_rst_n,
	input  wire logic  i_scl,
	input  wire logic  i_sda,
	output ccr_line_s  o_line
);

	logic scl_a_ff;
	logic scl_b_ff;
	logic sda_a_ff;
	logic sda_b_ff;

	// idle bus is high, so reset to high avoids a false start
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			scl_a_ff <= 1'b1;
			scl_b_ff <= 1'b1;
			sda_a_ff <= 1'b1;
			sda_b_ff <= 1'b1;
		end else begin
			scl_a_ff <= i_scl;
			scl_b_ff <= scl_a_ff;
			sda_a_ff <= i_sda;
			sda_b_ff <= sda_a_ff;
		end
	end

	// data moving while clock stays high marks start or stop
	always_comb begin
		o_line.scl_rise = scl_a_ff & ~scl_b_ff;
		o_line.scl_fall = ~scl_a_ff & scl_b_ff;
		o_line.start    = scl_a_ff & scl_b_ff & ~sda_a_ff & sda_b_ff;
		o_line.stop     = scl_a_ff & scl_b_ff & sda_a_ff & ~sda_b_ff;
		o_line.sda      = sda_a_ff;
	end

endmodule : ccr_line_mon

`default_nettype wire

// File: src/ccr_regs_top.sv
// Purpose : configuration and charge-current registers behind a serial slave port
// Assumes : master drives all clock pulses, no clock stretching is needed
// Notes   : settings leave as decoded levels, one cycle after the register changes
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module ccr_regs_top
	import ccr_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = `CCR_DEV_ADDR
)(
	input  wire logic         I_REF_CLK,
	input  wire logic         I_RST_N,
	input  wire logic         I_SCL,
	input  wire logic         I_SDA,
	output logic              O_SDA,
	output logic              O_SDA_OE,
	output logic              O_REG_RESET,
	output logic              O_WDT_RESTART,
	output logic              O_BOOST_EN,
	output logic              O_CHARGE_EN,
	output logic [12:0]       O_MIN_SYSTEM_VOLTAGE_MV,
	output logic              O_BOOST_ILIM_HI,
	output logic [12:0]       O_FAST_CHG_PROG_MA,
	output logic [12:0]       O_FAST_CHG_MA,
	output logic              O_BCOLD_SEL,
	output logic              O_PRECHG_HALF
);

	// ****************************************************************
	// decode helpers
	// ****************************************************************
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a == `CCR_OFS_CFG) || (a == `CCR_OFS_CHG);
	endfunction : is_mapped

	function automatic logic [12:0] sys_mv(input logic [2:0] c);
		sys_mv = `CCR_SYS_BASE_MV + 13'({10'h000, c} * `CCR_SYS_STEP_MV); // [R07]
	endfunction : sys_mv

	function automatic logic [12:0] fchg_ma(input logic [5:0] c);
		fchg_ma = `CCR_FCHG_BASE_MA + {1'b0, c, 6'h00}; // [R08]
	endfunction : fchg_ma

	ccr_line_s   ln;
	ccr_state_e  state_ff;
	ccr_state_e  nxt_state;
	ccr_cfg_s    cfg_ff;
	ccr_chg_s    chg_ff;
	logic [7:0]  shift_ff;
	logic [3:0]  bitcnt_ff;
	logic [7:0]  ptr_ff;
	logic [7:0]  nxt_ptr;
	logic [7:0]  tx_ff;
	logic [7:0]  nxt_tx;
	logic        oe_ff;
	logic        nxt_oe;
	logic        wr_stb;
	logic        byte_end;
	logic [7:0]  rd_val;
	logic        wr_cfg;
	logic        wr_chg;
	logic        do_reset;
	logic        chg_written_ff;

	ccr_line_mon u_line (
		.i_clk   (I_REF_CLK),
		.i_rst_n (I_RST_N),
		.i_scl   (I_SCL),
		.i_sda   (I_SDA),
		.o_line  (ln)
	);

	// ****************************************************************
	// bit shifter and counter
	// ****************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			shift_ff  <= 8'h00;
			bitcnt_ff <= 4'h0;
		end else if (ln.start) begin
			bitcnt_ff <= 4'h0;
		end else if (ln.scl_rise) begin
			shift_ff  <= {shift_ff[6:0], ln.sda};
			bitcnt_ff <= bitcnt_ff + 4'h1;
		end else if (ln.scl_fall && nxt_state != state_ff) begin
			bitcnt_ff <= 4'h0; // every phase change restarts the count
		end
	end

	assign byte_end = ln.scl_fall && (bitcnt_ff == 4'h8);
	// bits 7 and 6 of configuration never hold a one, so they read as zero
	assign rd_val   = (ptr_ff == `CCR_OFS_CFG) ? cfg_ff :
	                  (ptr_ff == `CCR_OFS_CHG) ? chg_ff : 8'h00; // [R14]

	// ****************************************************************
	// transaction sequencer
	// ****************************************************************
	always_comb begin
		nxt_state = state_ff;
		nxt_ptr   = ptr_ff;
		nxt_tx    = tx_ff;
		nxt_oe    = oe_ff;
		wr_stb    = 1'b0;
		case (state_ff)
			ST_ADDR: begin
				if (byte_end) begin
					if (shift_ff[7:1] == DEV_ADDR) begin // [R13]
						nxt_state = ST_ADDR_AK;
						nxt_oe    = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_ADDR_AK: begin
				if (ln.scl_fall) begin
					if (shift_ff[1]) begin // direction bit, one bit older than ack sample
						nxt_state = ST_RD;
						nxt_tx    = rd_val;
						nxt_oe    = ~rd_val[7];
					end else begin
						nxt_state = ST_REG;
						nxt_oe    = 1'b0;
					end
				end
			end
			ST_REG: begin
				if (byte_end) begin
					// unmapped address: no ack, back to idle
					if (is_mapped(shift_ff)) begin
						nxt_state = ST_REG_AK;
						nxt_ptr   = shift_ff;
						nxt_oe    = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_WR: begin
				if (byte_end) begin
					if (is_mapped(ptr_ff)) begin
						wr_stb    = 1'b1; // [R13]
						nxt_state = ST_WR_AK;
						nxt_ptr   = ptr_ff + 8'h01;
						nxt_oe    = 1'b1;
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			ST_REG_AK, ST_WR_AK: begin
				if (ln.scl_fall) begin
					nxt_state = ST_WR;
					nxt_oe    = 1'b0;
				end
			end
			ST_RD: begin
				if (byte_end) begin
					nxt_state = ST_RD_AK;
					nxt_ptr   = ptr_ff + 8'h01;
					nxt_oe    = 1'b0;
				end else if (ln.scl_fall) begin
					nxt_tx = {tx_ff[6:0], 1'b0};
					nxt_oe = ~tx_ff[6];
				end
			end
			ST_RD_AK: begin
				if (ln.scl_fall) begin
					// master ack (low) asks for the next byte
					if (!shift_ff[0]) begin
						nxt_state = ST_RD;
						nxt_tx    = rd_val;
						nxt_oe    = ~rd_val[7];
					end else begin
						nxt_state = ST_IDLE;
					end
				end
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
	end

	// start and stop override any phase; data pin released on either
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			state_ff <= ST_IDLE;
			ptr_ff   <= 8'h00;
			tx_ff    <= 8'h00;
			oe_ff    <= 1'b0;
		end else if (ln.start || ln.stop) begin
			state_ff <= ln.start ? ST_ADDR : ST_IDLE;
			oe_ff    <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			ptr_ff   <= nxt_ptr;
			tx_ff    <= nxt_tx;
			oe_ff    <= nxt_oe;
		end
	end

	assign O_SDA    = 1'b0; // open drain: only ever pulls low
	assign O_SDA_OE = oe_ff;

	// ****************************************************************
	// register storage
	// ****************************************************************
	assign wr_cfg   = wr_stb && (ptr_ff == `CCR_OFS_CFG);
	assign wr_chg   = wr_stb && (ptr_ff == `CCR_OFS_CHG);
	assign do_reset = wr_cfg && shift_ff[`CCR_BIT_REG_RST];

	// command bits are not stored, keeping them one-shot
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			cfg_ff <= `CCR_CFG_RST;
		end else if (do_reset) begin
			cfg_ff <= `CCR_CFG_RST; // [R01]
		end else if (wr_cfg) begin
			cfg_ff <= {2'b00, shift_ff[5:0]}; // [R14]
		end
	end

	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			chg_ff <= `CCR_CHG_RST; // [R12]
		end else if (do_reset) begin
			chg_ff <= `CCR_CHG_RST; // [R01]
		end else if (wr_chg) begin
			chg_ff <= shift_ff;
		end
	end

	// ****************************************************************
	// command pulses
	// ****************************************************************
	// register reset also goes out so the rest of the bank can follow,
	// it does not touch the device's operating mode
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_REG_RESET   <= 1'b0;
			O_WDT_RESTART <= 1'b0;
		end else begin
			O_REG_RESET   <= do_reset; // [R01]
			O_WDT_RESTART <= wr_cfg && shift_ff[`CCR_BIT_WDT_RST]; // [R02]
		end
	end

	// ****************************************************************
	// decoded settings
	// ****************************************************************
	// the divide by five is a constant divider; area traded for 20 percent, rounded down to whole mA
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			O_BOOST_EN         <= 1'b0;
			O_CHARGE_EN        <= 1'b1;
			O_MIN_SYSTEM_VOLTAGE_MV       <= `CCR_SYS_RST_MV;
			O_BOOST_ILIM_HI    <= 1'b1;
			O_FAST_CHG_PROG_MA <= `CCR_FCHG_RST_MA;
			O_FAST_CHG_MA      <= `CCR_FCHG_RST_MA;
			O_BCOLD_SEL        <= 1'b0;
			O_PRECHG_HALF      <= 1'b0;
		end else begin
			O_BOOST_EN         <= cfg_ff.boost_output_enable; // [R04]
			O_CHARGE_EN        <= cfg_ff.charge_enable_bit
			                      & ~cfg_ff.boost_output_enable; // [R05] [R06]
			O_MIN_SYSTEM_VOLTAGE_MV       <= sys_mv(cfg_ff.min_system_voltage); // [R07]
			O_BOOST_ILIM_HI    <= cfg_ff.boost_ilim_hi;
			O_FAST_CHG_PROG_MA <= fchg_ma(chg_ff.fast_charge_current); // [R08]
			O_FAST_CHG_MA      <= chg_ff.forced_reduced_current ?
			                      fchg_ma(chg_ff.fast_charge_current) / `CCR_FCHG_DIV :
			                      fchg_ma(chg_ff.fast_charge_current); // [R11]
			O_BCOLD_SEL        <= chg_ff.bcold_sel; // [R10]
			O_PRECHG_HALF      <= chg_ff.forced_reduced_current; // [R11]
		end
	end

	// ****************************************************************
	// checks
	// ****************************************************************
	always_ff @(posedge I_REF_CLK or negedge I_RST_N) begin
		if (!I_RST_N) begin
			chg_written_ff <= 1'b0;
		end else if (wr_chg || do_reset) begin
			chg_written_ff <= 1'b1;
		end
	end

	default clocking cb @(posedge I_REF_CLK); endclocking
	default disable iff (!I_RST_N);

	sequence s_cfg_reset_write;
		wr_cfg && shift_ff[`CCR_BIT_REG_RST];
	endsequence

	sequence s_addr_hit;
		state_ff == ST_ADDR && byte_end && shift_ff[7:1] == DEV_ADDR && !ln.start && !ln.stop;
	endsequence

	AST_REG_RESET_DEFAULTS: assert property (s_cfg_reset_write |=> // [R01]
		cfg_ff == `CCR_CFG_RST && chg_ff == `CCR_CHG_RST && O_REG_RESET ##1 !O_REG_RESET)
		else $error("register reset did not restore defaults");
	AST_WDT_ONE_PULSE: assert property ((wr_cfg && shift_ff[`CCR_BIT_WDT_RST]) |=> // [R02]
		O_WDT_RESTART ##1 !O_WDT_RESTART || $past(wr_cfg, 1))
		else $error("watchdog restart pulse wrong");
	AST_BOOST_FOLLOWS: assert property ((wr_cfg && !do_reset) |-> ##2 // [R04]
		O_BOOST_EN == $past(shift_ff[5], 2))
		else $error("boost enable does not follow write");
	AST_BOOST_PRIORITY: assert property (O_BOOST_EN |-> !O_CHARGE_EN) // [R05]
		else $error("charging while boost enabled");
	AST_CHARGE_EN: assert property (!O_BOOST_EN |-> // [R06]
		O_CHARGE_EN == $past(cfg_ff.charge_enable_bit))
		else $error("charge enable mismatch");
	AST_MIN_SYSTEM_VOLTAGE: assert property (O_MIN_SYSTEM_VOLTAGE_MV == `CCR_SYS_BASE_MV + // [R07]
		13'({10'h000, $past(cfg_ff.min_system_voltage)} * `CCR_SYS_STEP_MV))
		else $error("system voltage decode wrong");
	AST_FCHG_DECODE: assert property (!$past(chg_ff.forced_reduced_current) |-> // [R08]
		O_FAST_CHG_MA == O_FAST_CHG_PROG_MA)
		else $error("unscaled fast charge current wrong");
	AST_FORCE_SCALE: assert property ($past(chg_ff.forced_reduced_current) |-> // [R11]
		13'(O_FAST_CHG_MA * `CCR_FCHG_DIV) <= O_FAST_CHG_PROG_MA && O_PRECHG_HALF
		&& 13'((O_FAST_CHG_MA + 13'h0001) * `CCR_FCHG_DIV) > O_FAST_CHG_PROG_MA)
		else $error("reduced current not twenty percent");
	AST_BCOLD: assert property (O_BCOLD_SEL == $past(chg_ff.bcold_sel)) // [R10]
		else $error("cold threshold select mismatch");
	AST_CHG_RESET_VALUE: assert property (!chg_written_ff |-> chg_ff == 8'h60) // [R12]
		else $error("charge register not at reset value");
	AST_ADDR_ACK: assert property (s_addr_hit |=> O_SDA_OE && state_ff == ST_ADDR_AK) // [R13]
		else $error("own address not acknowledged");
	AST_CMD_READ_ZERO: assert property (cfg_ff[7:6] == 2'b00) // [R14]
		else $error("command bits read back nonzero");

endmodule : ccr_regs_top

`default_nettype wire

// File: bench/ccr_host_model.sv
// Purpose : host master on the two-wire serial port, bit level
// Assumes : bus wire resolved in tb with a pull-up
// Notes   : phases of 8 core clocks, twice what the slave needs
`timescale 1ns/1ps
`default_nettype none

module ccr_host_model (
	input  wire logic i_clk,
	input  wire logic i_sda,
	output logic      o_scl,
	output logic      o_sda_pull
);
	// ****************************************************************
	// bus primitives
	// ****************************************************************
	// idle bus at time zero, both lines released
	initial begin
		o_scl      = 1'b1;
		o_sda_pull = 1'b0;
	end

	// wait n clocks, then move just after the edge
	task automatic step(input int n);
		repeat (n) @(posedge i_clk);
		#1;
	endtask : step

	// start from idle or repeated start from a low clock
	task automatic start();
		o_sda_pull = 1'b0;
		step(6);
		o_scl = 1'b1;
		step(8);
		o_sda_pull = 1'b1;
		step(8);
		o_scl = 1'b0;
		step(2);
	endtask : start

	// data low first, so the rising data edge is the stop
	task automatic stop();
		o_sda_pull = 1'b1;
		step(6);
		o_scl = 1'b1;
		step(8);
		o_sda_pull = 1'b0;
		step(8);
	endtask : stop

	// data changes only while the clock is low, sampled mid-high
	task automatic bit_io(input logic b, output logic seen);
		o_sda_pull = ~b;
		step(6);
		o_scl = 1'b1;
		step(4);
		seen = i_sda;
		step(4);
		o_scl = 1'b0;
		step(2);
	endtask : bit_io

	// byte out msb first, ninth bit released to read the acknowledge
	task automatic send(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], s);
		end
		bit_io(1'b1, s);
		ack = ~s;
	endtask : send

	// byte in, then a not-acknowledge when it is the last one
	task automatic recv(input logic last, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(last, s);
	endtask : recv
endmodule : ccr_host_model
`default_nettype wire

// File: bench/tb.sv
// Purpose : self-checking bench for the charger register bank
// Assumes : host model drives the serial bus, pull-up on data
// Notes   : expected settings are computed from shadow register values
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defs.svh"

module tb;
	logic        clk;
	logic        rst_n;
	wire logic   scl;
	wire logic   host_pull;
	wire logic   sda_line;
	logic        sda_o;
	logic        sda_oe;
	logic        reg_rst;
	logic        wdt;
	logic        boost_en;
	logic        charge_en;
	logic [12:0] sys_mv;
	logic        ilim;
	logic [12:0] prog_ma;
	logic [12:0] fast_ma;
	logic        bcold;
	logic        half;
	int          fails;
	int          num_checks;
	int          wdt_cnt;
	int          rst_cnt;
	logic [7:0]  rb;
	logic [4:0]  ak;
	logic [7:0]  cfg;
	logic [7:0]  chg;
	// register, data: config rows read back with bits 7:6 clear
	logic [15:0] rows [9] = '{16'h0200, 16'h029C, 16'h029D, 16'h0262, 16'h0261,
		16'h0100, 16'h013E, 16'h012D, 16'h0111};

	// open-drain wire, pulled high when nobody pulls low
	assign sda_line = ~(host_pull | (sda_oe & ~sda_o));

	ccr_regs_top u_ccr_regs_top (.I_REF_CLK(clk), .I_RST_N(rst_n), .I_SCL(scl),
		.I_SDA(sda_line), .O_SDA(sda_o), .O_SDA_OE(sda_oe), .O_REG_RESET(reg_rst),
		.O_WDT_RESTART(wdt), .O_BOOST_EN(boost_en), .O_CHARGE_EN(charge_en),
		.O_MIN_SYSTEM_VOLTAGE_MV(sys_mv), .O_BOOST_ILIM_HI(ilim), .O_FAST_CHG_PROG_MA(prog_ma),
		.O_FAST_CHG_MA(fast_ma), .O_BCOLD_SEL(bcold), .O_PRECHG_HALF(half));
	ccr_host_model u_ccr_host_model (.i_clk(clk), .i_sda(sda_line), .o_scl(scl),
		.o_sda_pull(host_pull));

	// ****************************************************************
	// clock, pulse counters, hang guard
	// ****************************************************************
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// counting high cycles also catches a pulse wider than one clock
	always @(posedge clk) begin
		if (wdt === 1'b1) wdt_cnt++;
		if (reg_rst === 1'b1) rst_cnt++;
	end
	initial begin
		repeat (100000) @(posedge clk);
		fails++;
		end_sim();
	end

	// ****************************************************************
	// check and transfer tasks
	// ****************************************************************
	task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fails++;
			$display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic chk_out(input logic [7:0] c, input logic [7:0] q);
		logic [12:0] p;
		p = 13'h0200 + 13'h0040 * 13'(q[7:2]);
		chk(13'(boost_en), 13'(c[5]));
		chk(13'(charge_en), 13'(c[4] & ~c[5]));
		chk(sys_mv, 13'h0BB8 + 13'h0064 * 13'(c[3:1]));
		chk(13'(ilim), 13'(c[0]));
		chk(prog_ma, p);
		chk(fast_ma, q[0] ? p / 13'h0005 : p);
		chk(13'(bcold), 13'(q[1]));
		chk(13'(half), 13'(q[0]));
	endtask : chk_out

	// address phase shared by reads and writes
	task automatic head(input logic [7:0] ra, output logic [1:0] a);
		u_ccr_host_model.start();
		u_ccr_host_model.send({`CCR_DEV_ADDR, 1'b0}, a[1]);
		u_ccr_host_model.send(ra, a[0]);
	endtask : head

	task automatic wr(input logic [7:0] ra, input logic [7:0] d);
		logic [1:0] a;
		logic       a2;
		head(ra, a);
		u_ccr_host_model.send(d, a2);
		u_ccr_host_model.stop();
		chk(13'({a, a2}), 13'h0007);
	endtask : wr

	task automatic rd(input logic [7:0] ra, input logic [7:0] exp);
		logic [1:0] a;
		logic       a2;
		logic [7:0] d;
		head(ra, a);
		u_ccr_host_model.start();
		u_ccr_host_model.send({`CCR_DEV_ADDR, 1'b1}, a2);
		u_ccr_host_model.recv(1'b1, d);
		u_ccr_host_model.stop();
		chk(13'({a, a2}), 13'h0007);
		chk(13'(d), 13'(exp));
	endtask : rd

	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : end_sim

	// ****************************************************************
	// main sequence
	// ****************************************************************
	initial begin
		fails = 0;
		num_checks = 0;
		wdt_cnt = 0;
		rst_cnt = 0;
		rst_n = 1'b0;
		repeat (10) @(posedge clk);
		#1 rst_n = 1'b1;
		u_ccr_host_model.step(4);
		rd(8'h01, 8'h1B);
		rd(8'h02, 8'h60);
		chk_out(8'h1B, 8'h60);
		cfg = 8'h1B;
		chg = 8'h60;
		// fast-charge codes stay at or below 100111
		for (int i = 0; i < 9; i++) begin
			wr(rows[i][15:8], rows[i][7:0]);
			if (rows[i][8]) cfg = rows[i][7:0]; else chg = rows[i][7:0];
			rd(rows[i][15:8], rows[i][7:0] & (rows[i][8] ? 8'h3F : 8'hFF));
			chk_out(cfg, chg);
		end
		// multi-write, third data byte falls past the bank and is refused
		head(8'h01, ak[4:3]);
		u_ccr_host_model.send(8'h2A, ak[2]);
		u_ccr_host_model.send(8'h9C, ak[1]);
		u_ccr_host_model.send(8'h55, ak[0]);
		u_ccr_host_model.stop();
		chk(13'(ak), 13'h001E);
		chk_out(8'h2A, 8'h9C);
		// multi-read from the configuration register, master ack asks for the next one
		head(8'h01, ak[4:3]);
		u_ccr_host_model.start();
		u_ccr_host_model.send({`CCR_DEV_ADDR, 1'b1}, ak[2]);
		u_ccr_host_model.recv(1'b0, rb);
		chk(13'(rb), 13'h002A);
		u_ccr_host_model.recv(1'b1, rb);
		u_ccr_host_model.stop();
		chk(13'(rb), 13'h009C);
		chk(13'(ak[4:2]), 13'h0007);
		// undefined register and foreign address both go unanswered
		head(8'h03, ak[1:0]);
		u_ccr_host_model.stop();
		chk(13'(ak[1:0]), 13'h0002);
		u_ccr_host_model.start();
		u_ccr_host_model.send(8'hD4, ak[0]);
		u_ccr_host_model.stop();
		chk(13'(ak[0]), 13'h0000);
		// two watchdog restarts, spaced by the 20 us host minimum
		wr(8'h01, 8'h51);
		chk(13'(wdt_cnt), 13'h0001);
		rd(8'h01, 8'h11);
		u_ccr_host_model.step(`CCR_WDT_GAP_CYC);
		wr(8'h01, 8'h40);
		chk(13'(wdt_cnt), 13'h0002);
		chk_out(8'h00, 8'h9C);
		// register reset brings both registers back to defaults
		wr(8'h01, 8'h80);
		chk(13'(rst_cnt), 13'h0001);
		rd(8'h01, 8'h1B);
		rd(8'h02, 8'h60);
		chk_out(8'h1B, 8'h60);
		chk(13'(wdt_cnt), 13'h0002);
		// second power-on reset in mid-run
		wr(8'h02, 8'h01);
		rst_n = 1'b0;
		u_ccr_host_model.step(10);
		rst_n = 1'b1;
		u_ccr_host_model.step(4);
		chk_out(8'h1B, 8'h60);
		rd(8'h02, 8'h60);
		end_sim();
	end
endmodule : tb
`default_nettype wire
